/* File: verilog/sacc_top.v */
// Conversion control for a 10-bit successive-approximation converter
`include "sacc_defines.vh"
module sacc_top (
	input  wire                  REF_CLK_I,
	input  wire                  NRST_I,
	input  wire                  SC1_WR_I,
	input  wire [4:0]            SC1_CH_I,
	input  wire                  SC1_IRQ_EN_I,
	input  wire                  SC2_WR_I,
	input  wire                  SC2_CONT_I,
	input  wire                  SC2_CMP_EN_I,
	input  wire                  SC2_CMP_GE_I,
	input  wire                  SC2_HW_TRIG_I,
	input  wire                  CFG_WR_I,
	input  wire                  CFG_LOW_POWER_I,
	input  wire                  CFG_LONG_SAMPLE_I,
	input  wire                  CFG_MODE10_I,
	input  wire [1:0]            CFG_CLK_SEL_I,
	input  wire                  CVH_WR_I,
	input  wire                  CVL_WR_I,
	input  wire [9:0]            CMP_VALUE_I,
	input  wire                  RD_HIGH_I,
	input  wire                  RD_LOW_I,
	input  wire                  TRIG_I,
	input  wire                  STOP_ENTRY_I,
	input  wire                  DEEP_STOP_I,
	input  wire                  LVD_STOP_EN_I,
	input  wire                  CMP_I,
	output wire                  SAMPLE_O,
	output wire                  DAC_LOAD_O,
	output reg  [9:0]            DAC_CODE_O,
	output reg  [4:0]            CH_SEL_O,
	output reg  [7:0]            RESULT_HIGH_O,
	output reg  [7:0]            RESULT_LOW_O,
	output reg                   COMPLETE_O,
	output reg                   IRQ_O,
	output wire                  ACTIVE_O,
	output wire                  ASYNC_CLK_EN_O,
	output wire                  LOW_POWER_O
);
	localparam ST_IDLE = 2'h0;
	localparam ST_SMP  = 2'h1;
	localparam ST_SAR  = 2'h2;
	localparam ST_DONE = 2'h3;

	reg  [1:0] state_ff;
	reg  [1:0] nxt_state;
	reg  [4:0] smp_ff;
	reg  [4:0] nxt_smp;
	reg  [3:0] bit_ff;
	reg  [3:0] nxt_bit;
	reg  [9:0] sar_ff;
	reg  [9:0] nxt_sar;
	reg        block_ff;
	reg        nxt_block;
	reg  [9:0] nxt_result;
	reg        nxt_complete;
	reg        nxt_irq;
	reg  [4:0] nxt_ch;
	reg        xfer;
	reg        cmp_true;
	reg  [9:0] res_fmt;
	reg  [1:0] settle_ff;
	reg  [1:0] nxt_settle;
	wire       step;
	wire       trig_s;
	wire       cmp_s;
	wire       tick;
	wire       abort;
	wire       start;
	wire       stop_ok;
	wire [3:0] top_bit;

	// Analog comparator and trigger arrive from outside the clock domain
	sacc_sync u_sync_trig (
		.clk_i  (REF_CLK_I),
		.nrst_i (NRST_I),
		.d_i    (TRIG_I),
		.q_o    (trig_s)
	);
	sacc_sync u_sync_cmp (
		.clk_i  (REF_CLK_I),
		.nrst_i (NRST_I),
		.d_i    (CMP_I),
		.q_o    (cmp_s)
	);

	// Low power halves the tick rate, trading speed for current
	sacc_clk_div u_div (
		.clk_i  (REF_CLK_I),
		.nrst_i (NRST_I),
		.run_i  (state_ff != ST_IDLE),
		.div_i  (CFG_LOW_POWER_I ? `SACC_LP_DIV : `SACC_HP_DIV), // RL13
		.tick_o (tick)
	);

	// Deep stop keeps converting only with lvd stop enable set
	assign stop_ok = DEEP_STOP_I ? LVD_STOP_EN_I : 1'b1; // RL21
	assign abort   = SC1_WR_I || SC2_WR_I || CFG_WR_I || CVH_WR_I ||
			 CVL_WR_I ||
			 (STOP_ENTRY_I &&
			  CFG_CLK_SEL_I != `SACC_CLKSEL_ASYNC) || // RL9
			 (DEEP_STOP_I && !LVD_STOP_EN_I); // RL8
	// Hardware trigger is honoured in run and wait, and in deep stop only with lvd stop enable set
	assign start   = (SC1_WR_I && SC1_CH_I != `SACC_CH_OFF) || // RL7
			 (SC2_HW_TRIG_I && trig_s && stop_ok &&
			  CH_SEL_O != `SACC_CH_OFF); // RL20
	assign top_bit = CFG_MODE10_I ? `SACC_BITS_10 : `SACC_BITS_8; // RL16
	assign ACTIVE_O       = (state_ff != ST_IDLE);
	assign ASYNC_CLK_EN_O = ACTIVE_O &&
				(CFG_CLK_SEL_I == `SACC_CLKSEL_ASYNC); // RL12 RL19
	assign LOW_POWER_O    = CFG_LOW_POWER_I; // RL13
	assign SAMPLE_O       = (state_ff == ST_SMP); // RL14
	// Synced comparator lags the trial code by two edges: wait for it
	assign step           = tick && (settle_ff == 2'h2);
	assign DAC_LOAD_O     = (state_ff == ST_SAR) && step;

	always @* begin
		res_fmt = CFG_MODE10_I ? sar_ff : {2'h0, sar_ff[7:0]}; // RL16
		if (SC2_CMP_GE_I)
			cmp_true = (res_fmt >= CMP_VALUE_I); // RL18
		else
			cmp_true = (res_fmt < CMP_VALUE_I); // RL18
		if (!SC2_CMP_EN_I)
			cmp_true = 1'b1;
	end

	always @* begin
		nxt_state    = state_ff;
		nxt_smp      = smp_ff;
		nxt_bit      = bit_ff;
		nxt_sar      = sar_ff;
		nxt_block    = block_ff;
		nxt_result   = {RESULT_HIGH_O[1:0], RESULT_LOW_O};
		nxt_complete = COMPLETE_O;
		nxt_irq      = 1'b0;
		nxt_ch       = CH_SEL_O;
		nxt_settle   = (settle_ff == 2'h2) ? 2'h2 : settle_ff + 2'h1;
		xfer         = 1'b0;
		// Reading the low byte releases blocking; a high byte read in 10-bit mode arms it
		if (RD_LOW_I)
			nxt_block = 1'b0; // RL23
		if (RD_HIGH_I && CFG_MODE10_I)
			nxt_block = 1'b1; // RL23
		if (RD_LOW_I || SC1_WR_I)
			nxt_complete = 1'b0;
		if (SC1_WR_I)
			nxt_ch = SC1_CH_I; // RL15 RL22
		case (state_ff)
		ST_IDLE: begin
			nxt_state = ST_IDLE;
		end
		ST_SMP: begin
			if (tick) begin
				nxt_smp = smp_ff - 5'h01;
				if (smp_ff == 5'h00) begin
					nxt_state = ST_SAR; // RL14
					nxt_bit   = top_bit;
					nxt_sar   = 10'h000;
					nxt_settle = 2'h0;
				end
			end
		end
		ST_SAR: begin
			if (step) begin
				// Trial bit set first; comparator result keeps or drops it
				nxt_settle = 2'h0;
				nxt_sar = DAC_CODE_O;
				if (!cmp_s)
					nxt_sar[bit_ff] = 1'b0; // RL15
				if (bit_ff == 4'h0)
					nxt_state = ST_DONE;
				else
					nxt_bit = bit_ff - 4'h1;
			end
		end
		ST_DONE: begin
			nxt_state = ST_IDLE; // RL17
			if (!cmp_true && !SC2_CONT_I) begin
				nxt_state = ST_IDLE; // RL4
			end else if (block_ff && CFG_MODE10_I) begin
				nxt_state = ST_SMP; // RL3 RL5
			end else if (cmp_true) begin
				xfer         = 1'b1;
				nxt_result   = res_fmt; // RL1
				nxt_complete = 1'b1; // RL1
				nxt_irq      = SC1_IRQ_EN_I; // RL2
				if (SC2_CONT_I)
					nxt_state = ST_SMP; // RL17
			end else begin
				nxt_state = ST_SMP;
			end
		end
		default: begin
			nxt_state = ST_IDLE;
		end
		endcase
		if (nxt_state == ST_SMP && state_ff != ST_SMP)
			nxt_smp = CFG_LONG_SAMPLE_I ? `SACC_LONG_SMP
						    : `SACC_SHORT_SMP; // RL14
		// Abort keeps the old result; a start then begins fresh
		if (abort && !xfer) begin
			nxt_state = ST_IDLE; // RL10
		end
		if (start) begin
			nxt_state = ST_SMP; // RL7
			nxt_smp   = CFG_LONG_SAMPLE_I ? `SACC_LONG_SMP
						      : `SACC_SHORT_SMP;
		end
	end

	always @(posedge REF_CLK_I or negedge NRST_I) begin
		if (!NRST_I) begin
			state_ff      <= ST_IDLE; // RL9
			smp_ff        <= 5'h00;
			bit_ff        <= 4'h0;
			sar_ff        <= 10'h000;
			settle_ff     <= 2'h0;
			block_ff      <= 1'b0;
			RESULT_HIGH_O <= 8'h00; // RL11
			RESULT_LOW_O  <= 8'h00; // RL11
			COMPLETE_O    <= 1'b0;
			IRQ_O         <= 1'b0;
			CH_SEL_O      <= `SACC_CH_OFF;
			DAC_CODE_O    <= 10'h000;
		end else begin
			state_ff      <= nxt_state;
			smp_ff        <= nxt_smp;
			bit_ff        <= nxt_bit;
			sar_ff        <= nxt_sar;
			settle_ff     <= nxt_settle;
			block_ff      <= nxt_block;
			RESULT_HIGH_O <= {6'h00, nxt_result[9:8]};
			RESULT_LOW_O  <= nxt_result[7:0];
			COMPLETE_O    <= nxt_complete;
			IRQ_O         <= nxt_irq;
			CH_SEL_O      <= nxt_ch;
			DAC_CODE_O    <= 10'h000;
			if (nxt_state == ST_SAR) begin
				DAC_CODE_O          <= nxt_sar;
				DAC_CODE_O[nxt_bit] <= 1'b1;
			end
		end
	end
endmodule // sacc_top

/* File: shared/sacc_defines.vh */
// Constants for the successive-approximation converter control block
//
// Operation
// RL1 - Conversion finishes when result lands in result bytes; then complete flag sets
// RL2 - Interrupt pulses when complete flag sets, only if interrupt enable high
// RL3 - 10-bit: high byte read, low not yet: block transfer, drop result
// RL4 - Single conversion, compare on, condition false: ignore blocking, stop converting
// RL5 - Other blocked transfers restart a conversion, single or continuous
// RL6 - Software avoids reading results during a single conversion
// RL7 - Control-one write aborts and restarts unless channel field all ones
// RL8 - Control-two, config or compare value writes abort conversion as invalid
// RL9 - Abort on reset, and on stop entry without async clock enabled
// RL10 - Non-reset abort leaves result bytes holding last good result
// RL11 - Reset returns both result bytes to reset values
// RL12 - Idle until started; async clock generator on only while active and selected
// RL13 - Low-power bit lowers active power, lowering maximum conversion clock
// RL14 - Sample short or long per select bit, then isolate and approximate
// RL15 - Resolve 10 bits by successive approximation; up to 28 channels
// RL16 - Results right-justified, 10-bit or 8-bit per mode
// RL17 - Single or continuous conversion; single returns to idle
// RL18 - Optional compare, flag on less-than or greater-or-equal
// RL19 - Conversion clock selectable from four sources, one asynchronous
// RL20 - Wakeup timer trigger works in run, wait and deepest stop
// RL21 - Deepest stop operation only with lvd stop enable set
// RL22 - Channel 26 temperature sensor, 27 bandgap; long sample, clock at most 1 MHz
// RL23 - Arm blocking on high byte read in 10-bit mode, release on low read
`ifndef SACC_DEFINES_VH
`define SACC_DEFINES_VH
`define SACC_CH_W          5
`define SACC_CH_OFF        5'h1f
`define SACC_CH_TEMP       5'h1a
`define SACC_CH_BGAP       5'h1b
`define SACC_CH_LAST       5'h1b
`define SACC_RES_W         10
`define SACC_RES_RST       10'h000
`define SACC_BITS_10       4'h9
`define SACC_BITS_8        4'h7
`define SACC_SHORT_SMP     5'h03
`define SACC_LONG_SMP      5'h13
`define SACC_CLKSEL_ASYNC  2'h3
`define SACC_LP_DIV        2'h1
`define SACC_HP_DIV        2'h0
`endif

/* File: verilog/sacc_clk_div.v */
// Conversion clock enable generator dividing the reference clock by div_i plus one
`include "sacc_defines.vh"
module sacc_clk_div (
	input  wire       clk_i,
	input  wire       nrst_i,
	input  wire       run_i,
	input  wire [1:0] div_i,
	output reg        tick_o
);
	reg [1:0] cnt_ff;
	reg [1:0] nxt_cnt;
	always @* begin
		nxt_cnt = cnt_ff + 2'h1;
		if (!run_i || cnt_ff >= div_i)
			nxt_cnt = 2'h0;
	end
	always @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			cnt_ff <= 2'h0;
			tick_o <= 1'b0;
		end else begin
			cnt_ff <= nxt_cnt;
			tick_o <= run_i && (cnt_ff >= div_i);
		end
	end
endmodule // sacc_clk_div

/* File: verilog/sacc_sync.v */
// Two flip-flop synchroniser for one level
module sacc_sync (
	input  wire clk_i,
	input  wire nrst_i,
	input  wire d_i,
	output reg  q_o
);
	reg meta_ff;
	always @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			meta_ff <= 1'b0;
			q_o     <= 1'b0;
		end else begin
			meta_ff <= d_i;
			q_o     <= meta_ff;
		end
	end
endmodule // sacc_sync

/* File: sim/sacc_ana_model.sv */
// Analog side model: input voltage against the trial code
module sacc_ana_model (
	input  wire logic [9:0] vin_i,
	input  wire logic [9:0] dac_i,
	output logic            cmp_o
);
	timeunit 1ns;
	timeprecision 1ps;
	// Ideal comparator, so the settled code equals vin_i
	assign cmp_o = (vin_i >= dac_i);
endmodule // sacc_ana_model

/* File: sim/sacc_top_sva.sv */
// Port checker for the converter control block
module sacc_top_sva (
	input wire logic       REF_CLK_I,
	input wire logic       NRST_I,
	input wire logic       SC1_WR_I,
	input wire logic [4:0] SC1_CH_I,
	input wire logic       SC1_IRQ_EN_I,
	input wire logic       SC2_HW_TRIG_I,
	input wire logic       CFG_WR_I,
	input wire logic       CFG_MODE10_I,
	input wire logic [1:0] CFG_CLK_SEL_I,
	input wire logic       RD_HIGH_I,
	input wire logic       RD_LOW_I,
	input wire logic       STOP_ENTRY_I,
	input wire logic       SAMPLE_O,
	input wire logic       DAC_LOAD_O,
	input wire logic [7:0] RESULT_LOW_O,
	input wire logic       COMPLETE_O,
	input wire logic       IRQ_O,
	input wire logic       ACTIVE_O,
	input wire logic       ASYNC_CLK_EN_O
);
	timeunit 1ns;
	timeprecision 1ps;
	logic armed_ff;
	default clocking @(posedge REF_CLK_I); endclocking
	default disable iff (!NRST_I);
	always_ff @(posedge REF_CLK_I or negedge NRST_I) begin
		if (!NRST_I)
			armed_ff <= 1'b0;
		else if (RD_LOW_I)
			armed_ff <= 1'b0;
		else if (RD_HIGH_I && CFG_MODE10_I)
			armed_ff <= 1'b1;
	end
	sequence s_start;
		SC1_WR_I && SC1_CH_I != 5'h1f;
	endsequence
	sequence s_quiet;
		!SC1_WR_I && !SC2_HW_TRIG_I;
	endsequence
	AST_START: assert property (s_start |=> ACTIVE_O && SAMPLE_O)
		else $error("start write did not begin sampling");
	AST_CH_OFF: assert property (SC1_WR_I && SC1_CH_I == 5'h1f
		&& !SC2_HW_TRIG_I |=> !ACTIVE_O)
		else $error("all-ones channel write left converter active");
	AST_CFG_ABORT: assert property (CFG_WR_I ##0 s_quiet |=> !ACTIVE_O)
		else $error("config write did not abort");
	AST_STOP_ABORT: assert property (STOP_ENTRY_I && CFG_CLK_SEL_I != 2'h3
		##0 s_quiet |=> !ACTIVE_O)
		else $error("stop entry did not abort");
	AST_IDLE: assert property (!ACTIVE_O |-> !SAMPLE_O && !DAC_LOAD_O)
		else $error("idle converter sampling or stepping");
	AST_ASYNC_EN: assert property (ASYNC_CLK_EN_O |-> ACTIVE_O)
		else $error("async clock enabled while idle");
	AST_IRQ_FLAG: assert property (IRQ_O |-> COMPLETE_O)
		else $error("interrupt without complete flag");
	AST_IRQ_SET: assert property ($rose(COMPLETE_O) && $past(SC1_IRQ_EN_I)
		|-> IRQ_O)
		else $error("enabled interrupt missing");
	AST_RESULT: assert property (!$stable(RESULT_LOW_O) |-> COMPLETE_O)
		else $error("result moved without complete flag");
	AST_HOLD: assert property (COMPLETE_O && !RD_LOW_I ##0 s_quiet
		|=> COMPLETE_O)
		else $error("complete flag dropped");
	AST_BLOCK: assert property (armed_ff && !RD_LOW_I
		|=> $stable(RESULT_LOW_O) && !$rose(COMPLETE_O))
		else $error("transfer while read in progress");
endmodule // sacc_top_sva
bind sacc_top sacc_top_sva i_sacc_top_sva (.*);

/* File: sim/tb.sv */
// Directed testbench for the converter control block
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic REF_CLK_I = 0, NRST_I = 0, SC1_WR_I = 0, SC1_IRQ_EN_I = 1;
	logic SC2_WR_I = 0, SC2_CONT_I = 0, SC2_CMP_EN_I = 0, SC2_CMP_GE_I = 1;
	logic SC2_HW_TRIG_I = 0, CFG_WR_I = 0, CFG_LOW_POWER_I = 0;
	logic CFG_LONG_SAMPLE_I = 0, CFG_MODE10_I = 1, CVH_WR_I = 0, CVL_WR_I = 0;
	logic RD_HIGH_I = 0, RD_LOW_I = 0, TRIG_I = 0, STOP_ENTRY_I = 0;
	logic DEEP_STOP_I = 0, LVD_STOP_EN_I = 0;
	logic [4:0] SC1_CH_I = 5'h1f;
	logic [1:0] CFG_CLK_SEL_I = 2'h0;
	logic [9:0] CMP_VALUE_I = 10'h000, vin = 10'h2a5;
	wire CMP_I, SAMPLE_O, DAC_LOAD_O, COMPLETE_O, IRQ_O, ACTIVE_O;
	wire ASYNC_CLK_EN_O, LOW_POWER_O;
	wire [9:0] DAC_CODE_O;
	wire [4:0] CH_SEL_O;
	wire [7:0] RESULT_HIGH_O, RESULT_LOW_O;
	int n_fail = 0, tests_run = 0;
	bit got, irq;
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin n_fail++; \
	$display("MISMATCH t=%0t got %h exp %h", $time, a, e); end end
	always #25 REF_CLK_I = ~REF_CLK_I;
	sacc_top i_sacc_top (.*);
	sacc_ana_model i_sacc_ana_model (.vin_i(vin), .dac_i(DAC_CODE_O),
		.cmp_o(CMP_I));
	task close_out;
		$display("checks %0d mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	task automatic pulse(ref logic s);
		@(negedge REF_CLK_I) s = 1;
		@(negedge REF_CLK_I) s = 0;
	endtask
	task start(input logic [4:0] ch);
		@(negedge REF_CLK_I) SC1_CH_I = ch;
		SC1_WR_I = 1;
		@(negedge REF_CLK_I) SC1_WR_I = 0;
	endtask
	// A missed completion ends the run when must is set: later steps would only cascade
	task wait_cc(input int n, input bit must);
		got = 0;
		irq = 0;
		repeat (n) if (!got) begin
			@(negedge REF_CLK_I);
			irq |= IRQ_O;
			got = (COMPLETE_O === 1'b1);
		end
		if (must && !got) begin
			n_fail++;
			$display("MISMATCH t=%0t no completion", $time);
			close_out;
		end
	endtask
	task abrt(input int k);
		start(5'h03);
		repeat (3) @(negedge REF_CLK_I);
		case (k)
			0: CFG_WR_I = 1;
			1: SC2_WR_I = 1;
			2: CVH_WR_I = 1;
			3: CVL_WR_I = 1;
			4: STOP_ENTRY_I = 1;
			5: DEEP_STOP_I = 1;
			default: begin
				SC1_CH_I = 5'h1f;
				SC1_WR_I = 1;
			end
		endcase
		@(negedge REF_CLK_I) {CFG_WR_I, SC2_WR_I, CVH_WR_I} = 3'h0;
		{CVL_WR_I, STOP_ENTRY_I, SC1_WR_I} = 3'h0;
		DEEP_STOP_I = 0;
		@(negedge REF_CLK_I) `CHK(ACTIVE_O, 1'b0)
		`CHK(RESULT_LOW_O, 8'hf3)
	endtask
	initial begin
		repeat (6) @(negedge REF_CLK_I);
		NRST_I = 1;
		`CHK({RESULT_HIGH_O, RESULT_LOW_O}, 16'h0000)
		`CHK({CH_SEL_O, ACTIVE_O, ASYNC_CLK_EN_O}, 7'h7c)
		start(5'h02);
		wait_cc(800, 1);
		`CHK(irq, 1'b1)
		`CHK({RESULT_HIGH_O, RESULT_LOW_O}, 16'h02a5)
		`CHK({CH_SEL_O, ACTIVE_O}, 6'h04)
		pulse(RD_HIGH_I);
		vin = 10'h0f3;
		start(5'h02);
		wait_cc(600, 0);
		`CHK({got, ACTIVE_O}, 2'b01)
		`CHK(RESULT_LOW_O, 8'ha5)
		pulse(RD_LOW_I);
		wait_cc(800, 1);
		`CHK({RESULT_HIGH_O, RESULT_LOW_O}, 16'h00f3)
		for (int k = 0; k < 7; k++) abrt(k);
		CFG_CLK_SEL_I = 2'h3;
		CFG_LOW_POWER_I = 1;
		start(5'h1a);
		`CHK({ASYNC_CLK_EN_O, LOW_POWER_O}, 2'b11)
		wait_cc(1600, 1);
		CFG_CLK_SEL_I = 2'h0;
		CFG_LOW_POWER_I = 0;
		CFG_MODE10_I = 0;
		CFG_LONG_SAMPLE_I = 1;
		SC1_IRQ_EN_I = 0;
		start(5'h1b);
		wait_cc(1600, 1);
		`CHK({irq, RESULT_HIGH_O}, 9'h000)
		CFG_MODE10_I = 1;
		CFG_LONG_SAMPLE_I = 0;
		SC2_CONT_I = 1;
		start(5'h02);
		wait_cc(800, 1);
		pulse(RD_LOW_I);
		wait_cc(800, 1);
		`CHK(ACTIVE_O, 1'b1)
		start(5'h1f);
		SC2_CONT_I = 0;
		`CHK(ACTIVE_O, 1'b0)
		SC2_CMP_EN_I = 1;
		CMP_VALUE_I = 10'h3ff;
		start(5'h02);
		wait_cc(800, 0);
		`CHK({got, ACTIVE_O}, 2'b00)
		CMP_VALUE_I = 10'h000;
		vin = 10'h15a;
		start(5'h02);
		wait_cc(800, 1);
		`CHK(RESULT_LOW_O, 8'h5a)
		SC2_CMP_EN_I = 0;
		pulse(RD_LOW_I);
		SC2_HW_TRIG_I = 1;
		DEEP_STOP_I = 1;
		LVD_STOP_EN_I = 1;
		vin = 10'h2c3;
		pulse(TRIG_I);
		wait_cc(800, 1);
		`CHK({RESULT_HIGH_O, RESULT_LOW_O}, 16'h02c3)
		`CHK(ACTIVE_O, 1'b0)
		close_out;
	end
endmodule // tb
